// [dv/nrf_node_model.sv]
// Remote node model: sends request headers and collects the filter verdicts
`timescale 1ns/1ps

module nrf_node_model (
    // Clock
    input  wire logic              clk,
    // Request out, verdict back
    output nrf_pkg::nrf_req_t      rxReq,
    input  wire nrf_pkg::nrf_dec_t rxDec
);
    import nrf_pkg::*;

    // Idle header at time zero
    initial begin
        rxReq = '0;
    end

    // One header per call; idle fields flipped so a stale header never matches
    task automatic send(input logic [5:0] n, input logic loc, input logic ph,
                        output nrf_dec_t d);
        @(posedge clk);
        rxReq <= '{valid: 1'b1, srcLocal: loc, toPhys: ph, srcNode: n};
        @(posedge clk);
        rxReq <= '{valid: 1'b0, srcLocal: !loc, toPhys: !ph, srcNode: ~n};
        // Verdict stands one cycle only, so it is taken mid-cycle
        @(negedge clk);
        d = rxDec;
    endtask : send
endmodule : nrf_node_model

// [dv/test_node_request_filter.sv]
// Testbench of the node request filter: register access and per-node verdicts
`timescale 1ns/1ps

module test_node_request_filter;
    import nrf_pkg::*;

    // ****************************************************************
    // Signals and expected bitmaps
    // ****************************************************************
    logic        clk, rst, busRst;
    logic        awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady;
    logic [11:0] awAddr, arAddr;
    logic [31:0] wData, rData, physLow, aLo, aHi, pHi, d;
    logic [1:0]  bResp, rResp, r;
    nrf_req_t    rxReq;
    nrf_dec_t    rxDec;
    int          n_fail, checked;

    // Design, bus and receive side driven; ce, prot and wstrb tied
    nrf_filter uut (.clk(clk), .rst(rst), .ce(1'b1),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .rxReq(rxReq), .busResetEvent(busRst),
        .physLowRouteBits(physLow), .rxDec(rxDec));
    nrf_node_model node (.clk(clk), .rxReq(rxReq), .rxDec(rxDec));

    // 250 MHz clock
    always #2 clk = ~clk;

    // ****************************************************************
    // Checks and verdict
    // ****************************************************************
    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Ready is looked at mid-cycle, where it is settled, and taken at the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
        logic ha, hw, doneA, doneW;
        int   i;
        @(posedge clk);
        {awValid, wValid, awAddr, wData} <= {2'b11, a, v};
        {doneA, doneW} = 2'b00;
        for (i = 0; i < 50 && !(doneA && doneW); i++) begin
            @(negedge clk);
            {ha, hw} = {awValid & awReady, wValid & wReady};
            @(posedge clk);
            if (ha) awValid <= 1'b0;
            if (hw) wValid <= 1'b0;
            {doneA, doneW} = {doneA | ha, doneW | hw};
        end
        if (!(doneA && doneW)) begin n_fail++; print_verdict(); end
        // Ready for the response is held until bvalid is seen high
        bReady <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            {ha, rsp} = {bValid, bResp};
            @(posedge clk);
            if (ha) bReady <= 1'b0;
            if (ha) break;
        end
        // Bounded waits: running out ends the run as a failure
        if (i == 50) begin n_fail++; print_verdict(); end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
        logic h;
        int   i;
        @(posedge clk);
        {arValid, arAddr} <= {1'b1, a};
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            h = arReady;
            @(posedge clk);
            if (h) {arValid, rReady} <= 2'b01;
            if (h) break;
        end
        if (i == 50) begin n_fail++; print_verdict(); end
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            {h, v, rsp} = {rValid, rData, rResp};
            @(posedge clk);
            if (h) rReady <= 1'b0;
            if (h) break;
        end
        if (i == 50) begin n_fail++; print_verdict(); end
    endtask : rd

    // Verdict worked out from the expected bitmaps; node 63 owns no bit
    function automatic logic [2:0] expDec(logic [5:0] n, logic loc, logic ph);
        logic acc, rt;
        acc = n[5] ? aHi[n[4:0]] : aLo[n[4:0]];
        rt  = ph & acc & (n[5] ? pHi[n[4:0]] : physLow[n[4:0]]);
        if (n == NRF_NODE_BCAST) {acc, rt} = 2'b00;
        if (!loc) {acc, rt} = ph ? {2{pHi[31]}} : {aHi[31], 1'b0};
        return {1'b1, acc, rt};
    endfunction : expDec

    // Every node, both localities, both destinations
    task automatic sweep();
        nrf_dec_t v;
        for (int n = 0; n < 64; n++) begin
            for (int c = 0; c < 4; c++) begin
                node.send(6'(n), c[1], c[0], v);
                chk("verdict", {29'h0, v}, {29'h0, expDec(6'(n), c[1], c[0])});
            end
        end
    endtask : sweep

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {clk, rst, busRst, awValid, wValid, bReady, arValid, rReady} = 8'h40;
        {awAddr, arAddr, wData, physLow, n_fail, checked} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(NRF_ASYNC_HIGH_SET + 12'(4 * i), d, r);
            chk("reset value", d, NRF_BITMAP_RESET);
        end
        rd(12'h118, d, r);
        chk("unmapped read", {r, d[29:0]}, {NRF_RESP_SLVERR, 30'h0});
        // Set, clear, and a clear of nothing
        aLo = 32'hA5A5_0F0F & ~32'h0000_FF01;
        wr(NRF_ASYNC_LOW_SET, 32'hA5A5_0F0F, r);
        chk("write resp", {30'h0, r}, {30'h0, NRF_RESP_OKAY});
        wr(NRF_ASYNC_LOW_CLR, 32'h0000_FF01, r);
        wr(NRF_ASYNC_LOW_CLR, 32'h0000_0000, r);
        rd(NRF_ASYNC_LOW_CLR, d, r);
        chk("low async", d, aLo);
        aHi = 32'h7F0F_F0F3;
        pHi = 32'h7FF8_5555 & ~32'h0000_0001;
        physLow <= 32'h3C3C_9669;
        wr(NRF_ASYNC_HIGH_SET, aHi, r);
        wr(NRF_PHYS_HIGH_SET, 32'h7FF8_5555, r);
        wr(NRF_PHYS_HIGH_CLR, 32'h0000_0001, r);
        rd(NRF_PHYS_HIGH_CLR, d, r);
        chk("high phys", d, pHi);
        sweep();
        // Remote buses admitted
        {aHi[31], pHi[31]} = 2'b11;
        wr(NRF_ASYNC_HIGH_SET, 32'h8000_0000, r);
        wr(NRF_PHYS_HIGH_SET, 32'h8000_0000, r);
        sweep();
        // Bus reset keeps only the remote bit of the physical bitmap
        @(posedge clk);
        busRst <= 1'b1;
        @(posedge clk);
        busRst <= 1'b0;
        pHi = pHi & NRF_BUSRST_KEEP;
        rd(NRF_PHYS_HIGH_SET, d, r);
        chk("phys after bus reset", d, pHi);
        rd(NRF_ASYNC_LOW_SET, d, r);
        chk("async after bus reset", d, aLo);
        wr(12'h118, 32'hFFFF_FFFF, r);
        chk("unmapped write", {30'h0, r}, {30'h0, NRF_RESP_SLVERR});
        sweep();
        print_verdict();
    end
endmodule : test_node_request_filter

// [verilog/nrf_filter.sv]
// Node request filter: async and physical per-node bitmaps with AXI4-Lite access
`timescale 1ns/1ps

module nrf_filter (
    // Clock, reset, enable
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              ce,
    // AXI4-Lite write address
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [nrf_pkg::NRF_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                        s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    input  wire logic [nrf_pkg::NRF_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    output logic [1:0]                             s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    input  wire logic [nrf_pkg::NRF_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                        s_axi_arprot,
    // AXI4-Lite read data
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    output logic [nrf_pkg::NRF_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    // Receive path, same clock
    input  wire nrf_pkg::nrf_req_t                 rxReq,
    input  wire logic                              busResetEvent,
    input  wire logic [31:0]                       physLowRouteBits,
    // Filter verdict
    output nrf_pkg::nrf_dec_t                      rxDec
);
    import nrf_pkg::*;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Bit of a split bitmap pair for one node; broadcast ID has none
    function automatic logic nodeBit(input logic [31:0] lowMap,
                                     input logic [31:0] highMap,
                                     input logic [5:0]  node);
        logic hit;
        hit = 1'b0;
        if (node < NRF_UPPER_FIRST) begin
            hit = lowMap[node[4:0]];
        end else if (node != NRF_NODE_BCAST) begin
            hit = highMap[node[4:0]];
        end
        return hit;
    endfunction : nodeBit

    // Byte strobes widened to a bit mask
    function automatic logic [31:0] strobeMask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strobeMask

    // One bitmap after a set or clear write; zero bits leave it alone
    function automatic logic [31:0] applyWrite(input logic [31:0] cur,
                                               input logic [31:0] mask,
                                               input logic        doSet,
                                               input logic        doClr);
        logic [31:0] nxt;
        nxt = cur;
        if (doSet) begin
            nxt = cur | mask;
        end else if (doClr) begin
            nxt = cur & ~mask;
        end
        return nxt;
    endfunction : applyWrite

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [31:0]           asyncLow_q;   // Lower async bitmap, nodes 31..0
    logic [31:0]           asyncHigh_q;  // Upper async bitmap, remote bit and nodes 62..32
    logic [31:0]           physHigh_q;   // Upper physical bitmap, remote bit and nodes 62..32
    logic [NRF_ADDR_W-1:0] awAddr_q;     // Held write address
    logic                  awHeld_q;     // Write address taken, not yet used
    logic [31:0]           wData_q;      // Held write data
    logic [3:0]            wStrb_q;      // Held write strobes
    logic                  wHeld_q;      // Write data taken, not yet used
    logic                  bValid_q;     // Write response pending
    logic [1:0]            bResp_q;      // Write response code
    logic                  rValid_q;     // Read data pending
    logic [31:0]           rData_q;      // Read data
    logic [1:0]            rResp_q;      // Read response code
    nrf_dec_t              dec_q;        // Registered verdict

    // ****************************************************************
    // Bus handshakes
    // ****************************************************************
    logic        wrFire;     // Address and data both held, write happens now
    logic [31:0] wrMask;     // Bits written as one, within enabled bytes
    logic        arFire;     // Read address taken this cycle
    logic        wrMapped;   // Write address hits a port

    // Readies drop while frozen so no beat is taken without being stored
    assign s_axi_awready = ce && !awHeld_q;
    assign s_axi_wready  = ce && !wHeld_q;
    assign s_axi_arready = ce && !rValid_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;

    assign wrFire = ce && awHeld_q && wHeld_q && !bValid_q;
    assign wrMask = wData_q & strobeMask(wStrb_q);
    assign arFire = s_axi_arvalid && s_axi_arready;

    // Port decode for writes
    always_comb begin
        unique case (awAddr_q)
            NRF_ASYNC_HIGH_SET, NRF_ASYNC_HIGH_CLR,
            NRF_ASYNC_LOW_SET,  NRF_ASYNC_LOW_CLR,
            NRF_PHYS_HIGH_SET,  NRF_PHYS_HIGH_CLR: wrMapped = 1'b1;
            default:                               wrMapped = 1'b0;
        endcase
    end

    // Write address holding; either channel may arrive first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeld_q <= 1'b0;
            end
        end
    end

    // Write data holding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // Write response, one per write, error for unmapped words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bValid_q <= 1'b0;
            bResp_q  <= NRF_RESP_OKAY;
        end else if (ce) begin
            if (wrFire) begin
                bValid_q <= 1'b1;
                bResp_q  <= wrMapped ? NRF_RESP_OKAY : NRF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    // Read data; set and clear ports both return the bitmap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rValid_q <= 1'b0;
            rData_q  <= NRF_READ_ZERO;
            rResp_q  <= NRF_RESP_OKAY;
        end else if (ce) begin
            if (arFire) begin
                rValid_q <= 1'b1;
                rResp_q  <= NRF_RESP_OKAY;
                unique case (s_axi_araddr)
                    NRF_ASYNC_HIGH_SET, NRF_ASYNC_HIGH_CLR: rData_q <= asyncHigh_q;
                    NRF_ASYNC_LOW_SET,  NRF_ASYNC_LOW_CLR:  rData_q <= asyncLow_q;
                    NRF_PHYS_HIGH_SET,  NRF_PHYS_HIGH_CLR:  rData_q <= physHigh_q;
                    default: begin
                        rData_q <= NRF_READ_ZERO;
                        rResp_q <= NRF_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                rValid_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Filter bitmaps
    // ****************************************************************

    // Lower async bitmap, same set/clear behaviour as the upper one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            asyncLow_q <= NRF_BITMAP_RESET;
        end else if (ce && wrFire) begin
            asyncLow_q <= applyWrite(asyncLow_q, wrMask,
                                     awAddr_q == NRF_ASYNC_LOW_SET,
                                     awAddr_q == NRF_ASYNC_LOW_CLR);
        end
    end

    // Upper async bitmap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            asyncHigh_q <= NRF_BITMAP_RESET;
        end else if (ce && wrFire) begin
            asyncHigh_q <= applyWrite(asyncHigh_q, wrMask,
                                      awAddr_q == NRF_ASYNC_HIGH_SET,
                                      awAddr_q == NRF_ASYNC_HIGH_CLR);
        end
    end

    // Upper physical bitmap; bus reset drops node bits first, a write
    // in the same cycle then lands on top so software is never lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            physHigh_q <= NRF_BITMAP_RESET;
        end else if (ce) begin
            physHigh_q <= applyWrite(busResetEvent ? (physHigh_q & NRF_BUSRST_KEEP)
                                                   : physHigh_q,
                                     wrMask,
                                     wrFire && awAddr_q == NRF_PHYS_HIGH_SET,
                                     wrFire && awAddr_q == NRF_PHYS_HIGH_CLR);
        end
    end

    // ****************************************************************
    // Request verdict
    // ****************************************************************
    logic asyncHit;  // Async filter passes this source
    logic physHit;   // Physical filter passes this source
    nrf_dec_t decD;  // Verdict before the output register

    // Per-node lookups; remote sources only see the remote-bus bits
    always_comb begin
        if (rxReq.srcLocal) begin
            asyncHit = nodeBit(asyncLow_q, asyncHigh_q, rxReq.srcNode);
            physHit  = nodeBit(physLowRouteBits, physHigh_q, rxReq.srcNode);
        end else begin
            asyncHit = asyncHigh_q[NRF_REMOTE_BIT];
            physHit  = physHigh_q[NRF_REMOTE_BIT];
        end
    end

    // Routing decision
    always_comb begin
        decD.valid     = rxReq.valid;
        decD.accept    = asyncHit;
        decD.routePhys = 1'b0;
        if (rxReq.toPhys && rxReq.srcLocal) begin
            // Second check after the async one; a miss falls back
            decD.routePhys = asyncHit && physHit;
        end else if (rxReq.toPhys) begin
            // Remote physical requests hinge on the remote-bus bit alone
            decD.accept    = physHit;
            decD.routePhys = physHit;
        end
    end

    // Verdict register, one cycle after the request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_q <= '0;
        end else if (ce) begin
            dec_q <= decD;
        end
    end

    assign rxDec = dec_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_reset_zero;
        @(posedge clk) $fell(rst) |-> (asyncLow_q == NRF_BITMAP_RESET) &&
                                      (physHigh_q == NRF_BITMAP_RESET);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("bitmap not zero after reset");

    property p_low_set;
        @(posedge clk) disable iff (rst)
        (wrFire && awAddr_q == NRF_ASYNC_LOW_SET)
            |=> ((asyncLow_q & $past(wrMask)) == $past(wrMask));
    endproperty
    a_low_set: assert property (p_low_set)
        else $error("low async set port missed a bit");

    property p_low_clr;
        @(posedge clk) disable iff (rst)
        (wrFire && awAddr_q == NRF_ASYNC_LOW_CLR) |=> ((asyncLow_q & $past(wrMask)) == '0);
    endproperty
    a_low_clr: assert property (p_low_clr)
        else $error("low async clear port left a bit");

    property p_only_ones;
        @(posedge clk) disable iff (rst)
        (wrFire && awAddr_q == NRF_ASYNC_LOW_SET)
            |=> ((asyncLow_q & ~$past(wrMask)) == ($past(asyncLow_q) & ~$past(wrMask)));
    endproperty
    a_only_ones: assert property (p_only_ones)
        else $error("zero-written bit changed");

    property p_phys_clr;
        @(posedge clk) disable iff (rst)
        (wrFire && awAddr_q == NRF_PHYS_HIGH_CLR) |=> ((physHigh_q & $past(wrMask)) == '0);
    endproperty
    a_phys_clr: assert property (p_phys_clr)
        else $error("physical clear port left a bit");

    property p_busrst_keep;
        @(posedge clk) disable iff (rst)
        (ce && busResetEvent && !wrFire)
            |=> (physHigh_q == ($past(physHigh_q) & NRF_BUSRST_KEEP));
    endproperty
    a_busrst_keep: assert property (p_busrst_keep)
        else $error("bus reset handled remote bit wrongly");

    property p_fallback;
        @(posedge clk) disable iff (rst)
        (ce && rxReq.valid && rxReq.toPhys && rxReq.srcLocal && asyncHit && !physHit)
            |=> (rxDec.valid && rxDec.accept && !rxDec.routePhys);
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("physical miss not routed to async context");

    property p_remote_phys;
        @(posedge clk) disable iff (rst)
        (ce && rxReq.valid && rxReq.toPhys && !rxReq.srcLocal)
            |=> (rxDec.accept == $past(physHigh_q[NRF_REMOTE_BIT]));
    endproperty
    a_remote_phys: assert property (p_remote_phys)
        else $error("remote physical ack not gated by bit 31");

    property p_remote_async;
        @(posedge clk) disable iff (rst)
        (ce && rxReq.valid && !rxReq.toPhys && !rxReq.srcLocal)
            |=> (rxDec.accept == $past(asyncHigh_q[NRF_REMOTE_BIT]));
    endproperty
    a_remote_async: assert property (p_remote_async)
        else $error("remote async accept not from bit 31");

    property p_local_async;
        @(posedge clk) disable iff (rst)
        (ce && rxReq.valid && !rxReq.toPhys && rxReq.srcLocal)
            |=> (rxDec.accept == $past(asyncHit)) && !rxDec.routePhys;
    endproperty
    a_local_async: assert property (p_local_async)
        else $error("local async verdict wrong");

    property p_local_phys;
        @(posedge clk) disable iff (rst)
        (ce && rxReq.valid && rxReq.toPhys && rxReq.srcLocal && asyncHit && physHit)
            |=> rxDec.routePhys;
    endproperty
    a_local_phys: assert property (p_local_phys)
        else $error("local physical hit not routed");

    property p_read_answer;
        @(posedge clk) disable iff (rst)
        arFire ##1 (ce && !s_axi_rready) [*2] |-> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read data not held");

endmodule : nrf_filter

// [verilog/nrf_pkg.sv]
// Package with register map, field constants and carrier types of the node request filter
package nrf_pkg;

    // ****************************************************************
    // Register bus geometry
    // ****************************************************************
    localparam int          NRF_ADDR_W   = 12;         // Byte address width on the bus
    localparam int          NRF_DATA_W   = 32;         // Data width on the bus

    // ****************************************************************
    // Register byte offsets (set and clear ports of each bitmap)
    // ****************************************************************
    localparam logic [11:0] NRF_ASYNC_HIGH_SET = 12'h100;  // Upper async bitmap, set port
    localparam logic [11:0] NRF_ASYNC_HIGH_CLR = 12'h104;  // Upper async bitmap, clear port
    localparam logic [11:0] NRF_ASYNC_LOW_SET  = 12'h108;  // Lower async bitmap, set port
    localparam logic [11:0] NRF_ASYNC_LOW_CLR  = 12'h10C;  // Lower async bitmap, clear port
    localparam logic [11:0] NRF_PHYS_HIGH_SET  = 12'h110;  // Upper physical bitmap, set port
    localparam logic [11:0] NRF_PHYS_HIGH_CLR  = 12'h114;  // Upper physical bitmap, clear port

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam logic [31:0] NRF_BITMAP_RESET   = 32'h0000_0000;  // All bitmaps at reset
    localparam int          NRF_REMOTE_BIT     = 31;             // Accept-remote-buses bit
    localparam logic [31:0] NRF_BUSRST_KEEP    = 32'h8000_0000;  // Bits kept over bus reset
    localparam logic [5:0]  NRF_UPPER_FIRST    = 6'h20;          // First node of upper bitmaps
    localparam logic [5:0]  NRF_NODE_BCAST     = 6'h3F;          // Broadcast ID, has no bit
    localparam logic [31:0] NRF_READ_ZERO      = 32'h0000_0000;  // Read data of unmapped word

    // ****************************************************************
    // Bus response codes
    // ****************************************************************
    localparam logic [1:0]  NRF_RESP_OKAY      = 2'h0;       // Access done
    localparam logic [1:0]  NRF_RESP_SLVERR    = 2'h2;       // Unmapped address

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    // Incoming request as seen by the receive path
    typedef struct packed {
        logic       valid;      // Header present this cycle
        logic       srcLocal;   // Source sits on our own bus
        logic       toPhys;     // Destined for the physical request context
        logic [5:0] srcNode;    // Source node ID
    } nrf_req_t;

    // Filter verdict for one request
    typedef struct packed {
        logic valid;            // Verdict present this cycle
        logic accept;           // Request acknowledged and kept
        logic routePhys;        // Kept in physical context, else async context
    } nrf_dec_t;

endpackage : nrf_pkg
